/* design/rsc_consts.svh */
// Offsets, field positions, reset values and timing counts of the strap capture.
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// ----------------------------------------------------------------
// Register map, byte addresses on the Avalon-MM slave
// ----------------------------------------------------------------
`define RSC_OFS_STATUS      4'h0
`define RSC_OFS_CONTROL     4'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSC_CTL_START_BIT   0
`define RSC_CTL_SOFT_BIT    1
`define RSC_STS_BUSY_BIT    8

// ----------------------------------------------------------------
// Strap vector: [6] inband, [5:4] mgmt_if, [3] start, [2:1] port6_if,
// [0] flow control. Default is the weak-pull level of each pin.
// ----------------------------------------------------------------
`define RSC_STRAP_W         7
`define RSC_STRAP_DEFAULT   7'h39
`define RSC_PULL_UP_MASK    7'h39

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSC_CLK_PERIOD_NS   10
`define RSC_SOFT_RST_NS     100
`define RSC_SOFT_RST_CYC    (`RSC_SOFT_RST_NS / `RSC_CLK_PERIOD_NS)
`define RSC_SYNC_STAGES     2

`endif

/* design/rsc_pkg.sv */
// Types shared by the strap capture block.
`default_nettype none
package rsc_pkg;

   // Latched strap levels, one field per strap function.
   typedef struct packed {
      logic       inband;
      logic [1:0] mgmt_if;
      logic       start;
      logic [1:0] port6_if;
      logic       flow_ctrl;
   } rsc_strap_t;

   typedef enum logic [1:0] {
      RSC_MGMT_MDIO,
      RSC_MGMT_I2C,
      RSC_MGMT_SPI
   } rsc_mgmt_mode_t;

   typedef enum logic [1:0] {
      RSC_P6_RGMII,
      RSC_P6_RMII,
      RSC_P6_RESERVED,
      RSC_P6_MII
   } rsc_port6_mode_t;

   typedef enum logic [1:0] {
      RSC_ST_HIZ,
      RSC_ST_SOFT,
      RSC_ST_SETTLE,
      RSC_ST_RUN
   } rsc_state_t;

endpackage

`default_nettype wire

/* design/rsc_strap_capture.sv */
// Strap capture: latches configuration straps at reset release.
// Summary of operation
// RULE_01 - Strap pins stay undriven during hardware or software reset.
// RULE_02 - Each strap level is sampled at reset release and sets its mode.
// RULE_03 - Each strap pin has a weak pull giving its default level.
// RULE_04 - After reset release every strap pin drives its normal function.
// RULE_05 - The in-band management strap is resampled on software resets too.
// RULE_06 - Management strap 00 selects MDIO, 01 I2C, 1x SPI (default).
// RULE_07 - Start strap 1 forwards at once; 0 waits for software start bit.
// RULE_08 - Port-6 strap 00 RGMII, 01 RMII, 10 reserved, 11 MII.
// RULE_09 - Flow strap 1 enables flow control on all ports; 0 disables it.
// RULE_10 - Latched strap values stay stable until the next reset.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_consts.svh"

module rsc_strap_capture
   import rsc_pkg::*;
#(
   parameter int SOFT_RST_CYC = `RSC_SOFT_RST_CYC
)
(
   // Clock and reset
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_reset_n,
   // Avalon-MM slave
   input  wire logic [3:0]             i_avs_address,
   input  wire logic                   i_avs_read,
   input  wire logic                   i_avs_write,
   input  wire logic [31:0]            i_avs_writedata,
   input  wire logic [3:0]             i_avs_byteenable,
   output logic      [31:0]            o_avs_readdata,
   output logic                        o_avs_waitrequest,
   // Strap pins, bit order as the strap vector
   input  wire logic [`RSC_STRAP_W-1:0] i_strap_pin,
   output logic      [`RSC_STRAP_W-1:0] o_strap_pin,
   output logic      [`RSC_STRAP_W-1:0] o_strap_oe,
   output logic      [`RSC_STRAP_W-1:0] o_strap_pull_en,
   output logic      [`RSC_STRAP_W-1:0] o_strap_pull_up,
   // Normal pin function from the rest of the switch
   input  wire logic [`RSC_STRAP_W-1:0] i_func_out,
   // Mode settings
   output rsc_strap_t                  o_strap,
   output rsc_mgmt_mode_t              o_mgmt_mode,
   output rsc_port6_mode_t             o_port6_mode,
   output logic                        o_inband_mgmt_en,
   output logic                        o_forward_en,
   output logic                        o_flow_ctrl_en,
   output logic                        o_cfg_busy
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------

   // Upper bit set means SPI whatever the lower bit says.
   function automatic rsc_mgmt_mode_t mgmt_decode(input logic [1:0] v);
      rsc_mgmt_mode_t m;
      m = RSC_MGMT_SPI;
      if (v == 2'h0)
         m = RSC_MGMT_MDIO;
      else if (v == 2'h1)
         m = RSC_MGMT_I2C;
      return m;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   rsc_state_t                state;
   rsc_state_t                next_state;
   logic [15:0]               cnt;
   logic [15:0]               next_cnt;
   logic [`RSC_STRAP_W-1:0]   sync1;
   logic [`RSC_STRAP_W-1:0]   sync2;
   rsc_strap_t                strap;
   logic                      start_bit;
   logic                      ack;
   logic [`RSC_STRAP_W-1:0]   drive_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire logic req      = i_avs_read | i_avs_write;
   wire logic wr_go    = i_avs_write & ack;
   wire logic hit_sts  = i_avs_address == `RSC_OFS_STATUS;
   wire logic hit_ctl  = i_avs_address == `RSC_OFS_CONTROL;
   wire logic wr_ctl   = wr_go & hit_ctl & i_avs_byteenable[0];
   wire logic wr_soft  = wr_ctl & i_avs_writedata[`RSC_CTL_SOFT_BIT];
   wire logic sampling = state == RSC_ST_SETTLE && cnt == 16'h0000;
   wire logic [31:0] rd_data =
      hit_sts ? {23'h000000, o_cfg_busy, 1'b0, strap} :
      hit_ctl ? {31'h00000000, start_bit} : 32'h00000000;

   // One wait cycle per access; unmapped reads return zero.
   assign o_avs_waitrequest = req & ~ack;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------

   // The hold and settle counts give the synchroniser time to carry
   // the released pin level before the capture takes it.
   always_comb
   begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         RSC_ST_HIZ:
         begin
            next_state = RSC_ST_SETTLE;
            next_cnt   = 16'(`RSC_SYNC_STAGES);
         end
         RSC_ST_SOFT:
         begin
            if (cnt == 16'h0000)
            begin
               next_state = RSC_ST_SETTLE;
               next_cnt   = 16'(`RSC_SYNC_STAGES);
            end
            else
               next_cnt = cnt - 16'h0001;
         end
         RSC_ST_SETTLE:
         begin
            if (cnt == 16'h0000)
               next_state = RSC_ST_RUN;
            else
               next_cnt = cnt - 16'h0001;
         end
         RSC_ST_RUN:
         begin
            if (wr_soft)                                          // RULE_05
            begin
               next_state = RSC_ST_SOFT;
               next_cnt   = 16'(SOFT_RST_CYC - 1);
            end
         end
         default:
            next_state = RSC_ST_HIZ;
      endcase
   end

   // State register.
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state <= RSC_ST_HIZ;
         cnt   <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // Pin synchroniser; only sync2 is read by logic.
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sync1 <= `RSC_STRAP_DEFAULT;
         sync2 <= `RSC_STRAP_DEFAULT;
      end
      else
      begin
         sync1 <= i_strap_pin;
         sync2 <= sync1;
      end
   end

   // Capture once per reset; held otherwise so later LED activity on
   // the shared pins cannot disturb the configuration.
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         strap <= `RSC_STRAP_DEFAULT;
      else if (sampling)
         strap <= sync2;                                   // RULE_02 RULE_10
   end

   // Software start bit, cleared by software reset.
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         start_bit <= 1'b0;
      else if (state == RSC_ST_SOFT)
         start_bit <= 1'b0;
      else if (wr_ctl)
         start_bit <= i_avs_writedata[`RSC_CTL_START_BIT];
   end

   // Bus answer and pin output data.
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         ack            <= 1'b0;
         o_avs_readdata <= 32'h00000000;
         drive_q        <= {`RSC_STRAP_W{1'b1}};
      end
      else
      begin
         ack            <= req & ~ack;
         o_avs_readdata <= rd_data;
         drive_q        <= i_func_out;
      end
   end

   // ----------------------------------------------------------------
   // Pins and mode outputs
   // ----------------------------------------------------------------

   // Drivers stay off in every state but RUN.
   wire logic run_now = state == RSC_ST_RUN;
   assign o_strap_oe      = {`RSC_STRAP_W{run_now}};           // RULE_01 RULE_04
   assign o_strap_pin     = drive_q;                                // RULE_04
   assign o_strap_pull_en = ~o_strap_oe;                            // RULE_03
   assign o_strap_pull_up = `RSC_PULL_UP_MASK;                      // RULE_03

   // Modes follow the latched straps.
   assign o_strap          = strap;
   assign o_mgmt_mode      = mgmt_decode(strap.mgmt_if);            // RULE_06
   assign o_port6_mode     = rsc_port6_mode_t'(strap.port6_if);     // RULE_08
   assign o_inband_mgmt_en = strap.inband;
   assign o_flow_ctrl_en   = strap.flow_ctrl;                       // RULE_09
   assign o_forward_en     = (strap.start | start_bit)
                             & state == RSC_ST_RUN;                 // RULE_07
   assign o_cfg_busy       = state != RSC_ST_RUN;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   sequence soft_req_s;
      state == RSC_ST_RUN && wr_soft;
   endsequence

   sequence soft_hold_s;
      state == RSC_ST_SOFT && o_strap_oe == '0;
   endsequence

   hiz_in_reset_a: assert property (                                // RULE_01
      state != RSC_ST_RUN |-> o_strap_oe == '0)
      else $error("strap pin driven during reset");

   capture_edge_a: assert property (                                // RULE_02
      sampling |=> strap == $past(sync2) && state == RSC_ST_RUN)
      else $error("strap not captured at release");

   pull_default_a: assert property (                                // RULE_03
      o_strap_oe == '0 |-> o_strap_pull_en == '1
         && o_strap_pull_up == `RSC_STRAP_DEFAULT)
      else $error("weak pull missing while undriven");

   drive_after_a: assert property (                                 // RULE_04
      $rose(state == RSC_ST_RUN) |-> o_strap_oe == '1 ##1 o_strap_oe == '1
         || state == RSC_ST_SOFT)
      else $error("strap pins not driven after release");

   soft_capture_a: assert property (                                // RULE_05
      soft_req_s |=> soft_hold_s ##[1:300] sampling)
      else $error("software reset does not resample");

   mgmt_decode_a: assert property (                                 // RULE_06
      strap.mgmt_if[1] |-> o_mgmt_mode == RSC_MGMT_SPI)
      else $error("management mode decode wrong");

   start_gate_a: assert property (                                  // RULE_07
      !strap.start && !start_bit |-> !o_forward_en)
      else $error("forwarding without start");

   port6_map_a: assert property (                                   // RULE_08
      strap.port6_if == 2'h3 |-> o_port6_mode == RSC_P6_MII)
      else $error("port 6 mode decode wrong");

   mgmt_low_a: assert property (                                    // RULE_06
      !strap.mgmt_if[1] |-> o_mgmt_mode ==
         (strap.mgmt_if[0] ? RSC_MGMT_I2C : RSC_MGMT_MDIO))
      else $error("management low codes decode wrong");

   start_run_a: assert property (                                   // RULE_07
      strap.start && state == RSC_ST_RUN |-> o_forward_en)
      else $error("start strap set but not forwarding");

   port6_rmii_a: assert property (                                  // RULE_08
      strap.port6_if == 2'h1 |-> o_port6_mode == RSC_P6_RMII)
      else $error("port 6 reduced mode decode wrong");

   flow_ctrl_a: assert property (                                   // RULE_09
      o_flow_ctrl_en == strap.flow_ctrl && $stable(o_flow_ctrl_en)
         || $past(sampling))
      else $error("flow control not from strap");

   strap_stable_a: assert property (                                // RULE_10
      state == RSC_ST_RUN && !$past(sampling) |-> $stable(strap))
      else $error("latched strap changed outside reset");

endmodule

`default_nettype wire

/* testbench/rsc_board.sv */
// Board model of the strap pins: strap resistors, weak pulls and drivers.
`timescale 1ns/1ps
`default_nettype none
module rsc_board
(
   // Clock
   input  wire logic       i_clk,
   // Pin controls from the block
   input  wire logic [6:0] i_oe,
   input  wire logic [6:0] i_pull_en,
   input  wire logic [6:0] i_pull_up,
   input  wire logic [6:0] i_drive,
   // Board strap resistors
   input  wire logic [6:0] i_val,
   input  wire logic [6:0] i_mask,
   // Resolved pin level
   output logic      [6:0] o_level
);
   logic [6:0] last = 7'h00;
   // A board resistor beats the weak pull; a pin nobody holds drifts.
   always_comb
   begin
      for (int b = 0; b < 7; b++)
      begin
         if (i_oe[b])
            o_level[b] = i_drive[b];
         else if (i_mask[b])
            o_level[b] = i_val[b];
         else if (i_pull_en[b])
            o_level[b] = i_pull_up[b];
         else
            o_level[b] = ~last[b];
      end
   end
   // Last level, so a floating pin never keeps a stale value.
   always_ff @(posedge i_clk) last <= o_level;
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the strap capture block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rsc_pkg::*;
   logic            clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [3:0]      adr = 4'h0;
   logic [31:0]     wdat = 32'h0, q;
   logic [6:0]      func = 7'h00, bval = 7'h00, bmask = 7'h00, s, pin;
   wire logic [31:0] rdat;
   wire logic       wreq, busy, inb, fwd, fc;
   wire logic [6:0] pout, oe, pen, pup;
   rsc_strap_t      st;
   rsc_mgmt_mode_t  mm;
   rsc_port6_mode_t pm;
   int              bad_count = 0, check_count = 0, seed = 71466;
   // Clock at 100 MHz.
   always #5 clk = ~clk;
   rsc_strap_capture #(.SOFT_RST_CYC(2)) dut (.i_sys_clk(clk),
      .i_reset_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_strap_pin(pin),
      .o_strap_pin(pout), .o_strap_oe(oe), .o_strap_pull_en(pen),
      .o_strap_pull_up(pup), .i_func_out(func), .o_strap(st),
      .o_mgmt_mode(mm), .o_port6_mode(pm), .o_inband_mgmt_en(inb),
      .o_forward_en(fwd), .o_flow_ctrl_en(fc), .o_cfg_busy(busy));
   rsc_board board (.i_clk(clk), .i_oe(oe), .i_pull_en(pen),
      .i_pull_up(pup), .i_drive(pout), .i_val(bval), .i_mask(bmask),
      .o_level(pin));
   // Compare and count.
   task automatic check(input string n, input logic [31:0] sn,
                        input logic [31:0] e);
      check_count++;
      if (sn !== e)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, sn);
      end
   endtask
   // One Avalon transfer; the request stands until the rising edge at
   // which waitrequest is low, read data is taken there, then released.
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      check("bus_answer", 32'(wreq), 32'h0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // Wait, bounded, until configuration is done.
   task automatic wait_run;
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end while (busy !== 1'b0 && n < 30);
      check("busy_end", 32'(busy), 32'h0);
   endtask
   // Hardware reset with the given board straps.
   task automatic hw_reset(input logic [6:0] v, input logic [6:0] m);
      @(posedge clk);
      bval <= v; bmask <= m; rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      check("oe_rst", 32'(oe), 32'h0);
      check("pull_rst", 32'(pen), 32'h7F);
      rst_n <= 1'b1;
      wait_run;
   endtask
   // Expected modes worked out from the strap levels alone.
   task automatic check_modes(input logic [6:0] v);
      int e;
      e = v[5] ? 2 : (v[4] ? 1 : 0);
      check("strap", 32'(st), 32'(v));
      check("mgmt", 32'(mm), e);
      check("port6", 32'(pm), 32'(v[2:1]));
      check("flow", 32'(fc), 32'(v[0]));
      check("inband", 32'(inb), 32'(v[6]));
      check("fwd", 32'(fwd), 32'(v[3]));
      check("oe_run", 32'(oe), 32'h7F);
      bus(1'b0, 4'h0, 32'h0);
      check("status", q, 32'(v));
   endtask
   // Verdict, printed once.
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog far beyond the roughly 125 cycles the run needs.
   initial
   begin
      #200000;
      bad_count++;
      end_of_test;
   end
   // Main sequence.
   initial
   begin
      hw_reset(7'h00, 7'h00);
      check("pull_dir", 32'(pup), 32'h39);
      check_modes(7'h39);
      for (int i = 0; i < 4; i++)
      begin
         s = 7'($random(seed));
         s[5:4] = i[1:0];
         s[2:1] = i[1:0];
         hw_reset(s, 7'h7F);
         check_modes(s);
         func <= ~s;
         repeat (4) @(posedge clk);
         check("hold", 32'(st), 32'(s));
      end
      // Start strap low: forwarding waits for the control bit.
      hw_reset(7'h30, 7'h7F);
      check_modes(7'h30);
      bus(1'b1, 4'h4, 32'h1);
      @(negedge clk);
      check("fwd_sw", 32'(fwd), 32'h1);
      bus(1'b0, 4'h4, 32'h0);
      check("ctl_rd", q, 32'h1);
      @(posedge clk);
      func <= 7'($random(seed));
      repeat (2) @(posedge clk);
      check("pin_func", 32'(pin), 32'(func));
      // Software reset resamples the in-band strap.
      bval <= 7'h4F;
      bus(1'b1, 4'h4, 32'h2);
      @(negedge clk);
      @(negedge clk);
      check("oe_soft", 32'(oe), 32'h0);
      check("busy_soft", 32'(busy), 32'h1);
      bus(1'b0, 4'h0, 32'h0);
      check("status_soft", q, 32'h130);
      wait_run;
      check_modes(7'h4F);
      bus(1'b1, 4'hC, 32'hFFFFFFFF);
      bus(1'b0, 4'hC, 32'h0);
      check("unmapped", q, 32'h0);
      check("unmapped_wr", 32'(busy), 32'h0);
      end_of_test;
   end
endmodule
`default_nettype wire
